// File: bench/mcu_spi_model.sv
/* Controller model: serial register master, mode 0, MSB first.
   Assumes mclk at 100 MHz; sck stands low outside frames. */
`timescale 1ns/1ps
`default_nettype none
module mcu_spi_model (
  input wire logic mclk,
  output logic csn_b,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // ----------------------------------------
  // Frame engine
  // ----------------------------------------
  initial begin
    csn_b = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // Half sck period of 100 ns, well above the sync need
  task automatic half();
    repeat (10) @(posedge mclk);
  endtask
  // One byte each way; miso taken at the sck rise
  task automatic shift(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi <= b[i];
      half();
      sck <= 1'b1;
      r[i] = miso;
      half();
      sck <= 1'b0;
    end
  endtask
  // Command byte then one data byte, nothing else
  task automatic frame(input logic [7:0] cmd, input logic [7:0] d,
                       output logic [7:0] r);
    logic [7:0] junk;
    csn_b <= 1'b0;
    half();
    shift(cmd, junk);
    shift(d, r);
    half();
    csn_b <= 1'b1;
    mosi <= ~mosi;  // Released line shows no stale level
    half();
  endtask
endmodule // mcu_spi_model
`default_nettype wire

// File: bench/radio_cfg_sva.sv
/* Port checker for the radio configuration block.
   Assumes one mclk domain and link pulses only from idle. */
`timescale 1ns/1ps
`default_nettype none
module radio_cfg_sva #(
  parameter int RETRY_STEP_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spi_csn_b,
  input wire logic spi_miso_oe,
  input wire logic tx_done,
  input wire logic [2:0] addr_bytes,
  input wire logic [4:0] addr_byte_enable,
  input wire logic [6:0] channel,
  input wire logic carrier_test_enable,
  input wire logic force_lock,
  input wire radio_cfg_pkg::rate_e data_rate,
  input wire radio_cfg_pkg::power_e tx_power_level,
  input wire logic retransmit_go,
  input wire logic retry_exhausted,
  input wire logic [3:0] retry_count,
  input wire logic [3:0] lost_packet_count
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic [4:0] mask_exp;  // Low addr_bytes bits set
  assign mask_exp = (5'h01 << addr_bytes) - 5'h01;
  // Minimum wait is one step plus one, step is at least 4
  sequence link_quiet;
    !(retransmit_go || retry_exhausted) [*4];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  width_code_a: assert property (addr_bytes inside {3'h0, 3'h3, 3'h4,
    3'h5}) else $error("address width out of range");
  byte_mask_a: assert property (addr_byte_enable == mask_exp)
    else $error("address byte mask wrong");
  rate_code_a: assert property (data_rate != radio_cfg_pkg::RATE_RESERVED)
    else $error("reserved rate decoded");
  retry_wait_a: assert property (tx_done |=> link_quiet)
    else $error("retry came too early");
  retry_count_a: assert property (retransmit_go |->
    retry_count == $past(retry_count) + 4'h1)
    else $error("retry count not advanced");
  give_up_a: assert property (retry_exhausted |-> retry_count == 4'h0 &&
    lost_packet_count == (($past(lost_packet_count) == 4'hf) ? 4'hf :
    $past(lost_packet_count) + 4'h1)) else $error("loss not counted");
  lost_source_a: assert property ($changed(lost_packet_count) |->
    retry_exhausted || lost_packet_count == 4'h0)
    else $error("lost count moved alone");
  fields_hold_a: assert property (spi_csn_b [*8] |-> $stable({channel,
    addr_bytes, data_rate, tx_power_level, carrier_test_enable,
    force_lock})) else $error("field moved without access");
  select_drive_a: assert property ($fell(spi_csn_b) |-> ##[2:6] spi_miso_oe)
    else $error("miso not driven when selected");
endmodule // radio_cfg_sva
bind radio_addr_retry_rate_config radio_cfg_sva #(
  .RETRY_STEP_CYCLES(RETRY_STEP_CYCLES)
) radio_cfg_sva_i (
  .mclk(mclk), .rst_b(rst_b), .spi_csn_b(spi_csn_b),
  .spi_miso_oe(spi_miso_oe), .tx_done(tx_done), .addr_bytes(addr_bytes),
  .addr_byte_enable(addr_byte_enable), .channel(channel),
  .carrier_test_enable(carrier_test_enable), .force_lock(force_lock),
  .data_rate(data_rate), .tx_power_level(tx_power_level),
  .retransmit_go(retransmit_go), .retry_exhausted(retry_exhausted),
  .retry_count(retry_count), .lost_packet_count(lost_packet_count)
);
`default_nettype wire

// File: bench/tb_radio_addr_retry_rate_config.sv
/* Testbench for the radio configuration block.
   Assumes the controller model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_radio_addr_retry_rate_config;
  logic mclk = 1'b0;
  logic rst_b, spi_csn_b, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  logic tx_done, ack_ok, carrier_test_enable, force_lock;
  logic retransmit_go, retry_exhausted;
  logic [2:0] addr_bytes;
  logic [4:0] addr_byte_enable;
  logic [6:0] channel;
  logic [3:0] retry_count, lost_packet_count;
  radio_cfg_pkg::rate_e data_rate;
  radio_cfg_pkg::power_e tx_power_level;
  int n_mismatch = 0;
  int comparisons = 0;
  always #5 mclk = ~mclk;
  radio_addr_retry_rate_config #(.RETRY_STEP_CYCLES(4))
  radio_addr_retry_rate_config_i (.*);
  mcu_spi_model mcu_spi_model_i (.mclk(mclk), .csn_b(spi_csn_b),
    .sck(spi_sck), .mosi(spi_mosi), .miso(spi_miso));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic rw(input logic [2:0] c, input logic [4:0] a,
                    input logic [7:0] d, output logic [7:0] r);
    mcu_spi_model_i.frame({c, a}, d, r);
  endtask
  // Pulse tx_done, count edges to the link answer
  task automatic kick(output int n);
    @(posedge mclk);
    tx_done <= 1'b1;
    @(posedge mclk);
    tx_done <= 1'b0;
    n = 0;
    while (!(retransmit_go || retry_exhausted) && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 300) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset();
    logic [7:0] r;
    logic [7:0] tab [4] = '{8'h03, 8'h03, 8'h02, 8'h0e};
    for (int a = 0; a < 5; a++) begin
      rw(3'h0, (a == 4) ? 5'h10 : 5'(a + 3), 8'h00, r);
      chk("reset reg", r, (a == 4) ? 8'h00 : tab[a]);
    end
  endtask
  task automatic s_width();
    logic [7:0] r;
    for (int c = 0; c < 4; c++) begin
      rw(3'h1, 5'h03, 8'hfc | 8'(c), r);
      rw(3'h0, 5'h03, 8'h00, r);
      chk("width reg", r, 8'(c));
      chk("bytes", addr_bytes, (c == 0) ? 8'h00 : 8'(c + 2));
      chk("mask", addr_byte_enable, (c == 0) ? 8'h00 :
          8'((1 << (c + 2)) - 1));
    end
  endtask
  task automatic s_rate();
    logic [7:0] r, v;
    for (int i = 0; i < 8; i++) begin
      v = {i[2], 1'b0, i[1], ~i[2], i[0], i[1:0], 1'b0};
      rw(3'h1, 5'h06, v | 8'h41, r);
      rw(3'h0, 5'h06, 8'h00, r);
      chk("setup reg", r, v);
      chk("rate", data_rate, i[1] ? 8'h02 : 8'(i[0]));
      chk("power", tx_power_level, 8'(i[1:0]));
      chk("carrier", carrier_test_enable, 8'(i[2]));
      chk("lock", force_lock, 8'(!i[2]));
    end
  endtask
  task automatic s_retry();
    logic [7:0] r;
    int n, seen;
    rw(3'h1, 5'h04, 8'h12, r);
    kick(n);
    @(posedge mclk);
    tx_done <= 1'b1;
    @(posedge mclk);
    tx_done <= 1'b0;
    ack_ok <= 1'b1;
    @(posedge mclk);
    ack_ok <= 1'b0;
    seen = 0;
    repeat (80) begin
      @(posedge mclk);
      #1;
      if ((retransmit_go | retry_exhausted) !== 1'b0) seen++;
    end
    chk("after ack", 8'(seen), 8'h00);
    chk("ack clears", retry_count, 8'h00);
    for (int k = 1; k <= 3; k++) begin
      kick(n);
      chk("wait", 8'(n), 8'h08);
      chk("give up", retry_exhausted, 8'(k == 3));
      chk("retries", retry_count, (k == 3) ? 8'h00 : 8'(k));
    end
    chk("lost", lost_packet_count, 8'h01);
    rw(3'h1, 5'h04, 8'hf0, r);
    kick(n);
    chk("long wait", 8'(n), 8'h40);
    chk("no retry", retry_exhausted, 8'h01);
    chk("lost two", lost_packet_count, 8'h02);
    rw(3'h1, 5'h05, 8'hff, r);
    chk("channel", channel, 8'h7f);
    chk("lost clear", lost_packet_count, 8'h00);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    tx_done = 1'b0;
    ack_ok = 1'b0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    s_reset();
    s_width();
    s_rate();
    s_retry();
    give_verdict();
  end
endmodule // tb_radio_addr_retry_rate_config
`default_nettype wire

// File: verilog/radio_addr_retry_rate_config.sv
/*
  Radio configuration register subset: address width, retransmission
  delay and limit, channel, and data rate / power / test setup. Holds
  the settings, decodes them for the link layer, times retransmissions
  and keeps the lost-packet counter.
  Assumes the controller reaches the registers only through the serial
  register commands and that link events are one-cycle mclk pulses.
*/
// What this block does
// - Address width code selects 3, 4, 5 bytes
// - Short addresses use least significant bytes only
// - Retry wait is 250 us steps after transmission
// - Retry limit 0 disables, 1-15 retries allowed
// - Seven-bit channel field selects radio channel
// - Carrier test bit alone enables unmodulated carrier
// - Low rate bit selects 250 kbps always
// - Force lock bit forces lock indication active
// - High rate bit ignored when low set
// - Rate pair decodes 1M, 2M, 250k, 250k (low bit wins)
// - Power field selects -18, -12, -6, 0 dBm
// - Access only through serial register read, write
// - Undefined register bits always read zero
// - Channel write clears lost packet counter
`timescale 1ns/1ps
`default_nettype none

module radio_addr_retry_rate_config #(
  parameter int RETRY_STEP_CYCLES = radio_cfg_pkg::RETRY_STEP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spi_csn_b,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic tx_done,
  input wire logic ack_ok,
  output logic [2:0] addr_bytes,
  output logic [4:0] addr_byte_enable,
  output logic [6:0] channel,
  output logic carrier_test_enable,
  output logic force_lock,
  output radio_cfg_pkg::rate_e data_rate,
  output radio_cfg_pkg::power_e tx_power_level,
  output logic retransmit_go,
  output logic retry_exhausted,
  output logic [3:0] retry_count,
  output logic [3:0] lost_packet_count
);

  // ----------------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------------
  radio_cfg_pkg::reg_req_s req;   // One-cycle write request
  logic [4:0] rd_addr;            // Address being read
  logic [7:0] rd_data;            // Read mux result

  spi_reg_port u_port (
    .mclk(mclk),
    .rst_b(rst_b),
    .spi_csn_b(spi_csn_b),
    .spi_sck(spi_sck),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .req(req),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [1:0] addr_length_field, next_addr_length_field;
  logic [3:0] retry_delay, next_retry_delay;
  logic [3:0] retry_limit, next_retry_limit;
  logic [6:0] radio_channel, next_radio_channel;
  logic rate_low_select, next_rate_low_select;
  logic rate_high_select, next_rate_high_select;
  logic force_lock_bit, next_force_lock_bit;
  logic carrier_bit, next_carrier_bit;
  logic [1:0] tx_power_field, next_tx_power_field;
  logic chan_write;               // Channel register written

  // Decode writes; reserved bits are dropped, fields hold otherwise
  always_comb begin
    next_addr_length_field = addr_length_field;
    next_retry_delay = retry_delay;
    next_retry_limit = retry_limit;
    next_radio_channel = radio_channel;
    next_rate_low_select = rate_low_select;
    next_rate_high_select = rate_high_select;
    next_force_lock_bit = force_lock_bit;
    next_carrier_bit = carrier_bit;
    next_tx_power_field = tx_power_field;
    chan_write = 1'b0;
    if (req.wr) begin
      unique case (req.addr)
        radio_cfg_pkg::ADDR_ADDRESS_WIDTH_SETUP: begin
          next_addr_length_field =
            req.wdata[radio_cfg_pkg::ADDR_LEN_LSB +: 2];
        end
        radio_cfg_pkg::ADDR_RETRANSMIT_SETUP: begin
          next_retry_delay =
            req.wdata[radio_cfg_pkg::RETRY_DELAY_LSB +: 4];
          next_retry_limit =
            req.wdata[radio_cfg_pkg::RETRY_LIMIT_LSB +: 4];
        end
        radio_cfg_pkg::ADDR_RADIO_CHANNEL: begin
          next_radio_channel =
            req.wdata[radio_cfg_pkg::CHANNEL_LSB +: 7];
          chan_write = 1'b1;
        end
        radio_cfg_pkg::ADDR_RADIO_SETUP: begin
          next_carrier_bit = req.wdata[radio_cfg_pkg::CARRIER_TEST_BIT];
          next_rate_low_select = req.wdata[radio_cfg_pkg::RATE_LOW_BIT];
          next_force_lock_bit = req.wdata[radio_cfg_pkg::FORCE_LOCK_BIT];
          next_rate_high_select = req.wdata[radio_cfg_pkg::RATE_HIGH_BIT];
          next_tx_power_field =
            req.wdata[radio_cfg_pkg::TX_POWER_LSB +: 2];
        end
        default: begin
          // Other addresses belong to other blocks
        end
      endcase
    end
  end

  // Store fields; reset restores every default
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      addr_length_field <= radio_cfg_pkg::RST_ADDR_LEN;
      retry_delay <= radio_cfg_pkg::RST_RETRY_DELAY;
      retry_limit <= radio_cfg_pkg::RST_RETRY_LIMIT;
      radio_channel <= radio_cfg_pkg::RST_CHANNEL;
      rate_low_select <= radio_cfg_pkg::RST_RATE_LOW;
      rate_high_select <= radio_cfg_pkg::RST_RATE_HIGH;
      force_lock_bit <= radio_cfg_pkg::RST_FORCE_LOCK;
      carrier_bit <= radio_cfg_pkg::RST_CARRIER_TEST;
      tx_power_field <= radio_cfg_pkg::RST_TX_POWER;
    end else begin
      addr_length_field <= next_addr_length_field;
      retry_delay <= next_retry_delay;
      retry_limit <= next_retry_limit;
      radio_channel <= next_radio_channel;
      rate_low_select <= next_rate_low_select;
      rate_high_select <= next_rate_high_select;
      force_lock_bit <= next_force_lock_bit;
      carrier_bit <= next_carrier_bit;
      tx_power_field <= next_tx_power_field;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Only defined fields are placed; everything else stays zero
  always_comb begin
    rd_data = 8'h00;
    unique case (rd_addr)
      radio_cfg_pkg::ADDR_ADDRESS_WIDTH_SETUP: begin
        rd_data[radio_cfg_pkg::ADDR_LEN_LSB +: 2] = addr_length_field;
      end
      radio_cfg_pkg::ADDR_RETRANSMIT_SETUP: begin
        rd_data[radio_cfg_pkg::RETRY_DELAY_LSB +: 4] = retry_delay;
        rd_data[radio_cfg_pkg::RETRY_LIMIT_LSB +: 4] = retry_limit;
      end
      radio_cfg_pkg::ADDR_RADIO_CHANNEL: begin
        rd_data[radio_cfg_pkg::CHANNEL_LSB +: 7] = radio_channel;
      end
      radio_cfg_pkg::ADDR_RADIO_SETUP: begin
        rd_data[radio_cfg_pkg::CARRIER_TEST_BIT] = carrier_bit;
        rd_data[radio_cfg_pkg::RATE_LOW_BIT] = rate_low_select;
        rd_data[radio_cfg_pkg::FORCE_LOCK_BIT] = force_lock_bit;
        rd_data[radio_cfg_pkg::RATE_HIGH_BIT] = rate_high_select;
        rd_data[radio_cfg_pkg::TX_POWER_LSB +: 2] = tx_power_field;
      end
      default: begin
        // Unmapped here: reads as zero
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Setting decode for the link layer
  // ----------------------------------------------------------------------
  // Illegal code 00 gives zero bytes so the link refuses to run on it
  always_comb begin
    unique case (addr_length_field)
      2'b01: addr_bytes = 3'h3;
      2'b10: addr_bytes = 3'h4;
      2'b11: addr_bytes = 3'h5;
      default: addr_bytes = 3'h0;
    endcase
    // Enabled bytes are always the low ones of a stored address
    addr_byte_enable = 5'(((1 << addr_bytes) - 1));
  end

  // Low rate bit wins; high bit only matters when low is clear
  always_comb begin
    if (rate_low_select) begin
      data_rate = radio_cfg_pkg::RATE_250K;
    end else if (rate_high_select) begin
      data_rate = radio_cfg_pkg::RATE_2M;
    end else begin
      data_rate = radio_cfg_pkg::RATE_1M;
    end
  end

  assign channel = radio_channel;
  assign carrier_test_enable = carrier_bit;
  assign force_lock = force_lock_bit;
  assign tx_power_level = radio_cfg_pkg::power_e'(tx_power_field);

  // ----------------------------------------------------------------------
  // Retransmission timer and lost-packet counter
  // ----------------------------------------------------------------------
  radio_cfg_pkg::retry_state_e state, next_state;
  logic [radio_cfg_pkg::WAIT_W-1:0] wait_cnt, next_wait_cnt;
  logic [3:0] next_retry_count, next_lost_count;
  logic next_retransmit_go, next_retry_exhausted;
  logic lost_event;

  // Wait of (code + 1) steps, minus the cycle that loads it
  function automatic logic [radio_cfg_pkg::WAIT_W-1:0] wait_load(
    input logic [3:0] code
  );
    wait_load = radio_cfg_pkg::WAIT_W'(
      (int'(code) + 1) * RETRY_STEP_CYCLES - 1);
  endfunction

  // Retry sequencing: wait starts at the end of each transmission
  always_comb begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    next_retry_count = retry_count;
    next_retransmit_go = 1'b0;
    next_retry_exhausted = 1'b0;
    lost_event = 1'b0;
    unique case (state)
      radio_cfg_pkg::RETRY_IDLE: begin
        if (tx_done) begin
          next_state = radio_cfg_pkg::RETRY_WAIT;
          next_wait_cnt = wait_load(retry_delay);
        end
      end
      radio_cfg_pkg::RETRY_WAIT: begin
        if (ack_ok) begin
          // Acknowledged: packet done, retries start over
          next_state = radio_cfg_pkg::RETRY_IDLE;
          next_retry_count = 4'h0;
        end else if (wait_cnt != '0) begin
          next_wait_cnt = wait_cnt - 1'b1;
        end else if (retry_count < retry_limit) begin
          next_state = radio_cfg_pkg::RETRY_IDLE;
          next_retransmit_go = 1'b1;
          next_retry_count = retry_count + 4'h1;
        end else begin
          // Limit reached, or zero limit: give the packet up
          next_state = radio_cfg_pkg::RETRY_IDLE;
          next_retry_exhausted = 1'b1;
          next_retry_count = 4'h0;
          lost_event = 1'b1;
        end
      end
    endcase
  end

  // Lost count saturates at 15; a loss in the clearing cycle still counts
  always_comb begin
    next_lost_count = lost_packet_count;
    if (chan_write) begin
      next_lost_count = lost_event ? 4'h1 : 4'h0;
    end else if (lost_event && lost_packet_count != 4'hF) begin
      next_lost_count = lost_packet_count + 4'h1;
    end
  end

  // Register the retry and loss state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= radio_cfg_pkg::RETRY_IDLE;
      wait_cnt <= '0;
      retry_count <= 4'h0;
      lost_packet_count <= 4'h0;
      retransmit_go <= 1'b0;
      retry_exhausted <= 1'b0;
    end else begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
      retry_count <= next_retry_count;
      lost_packet_count <= next_lost_count;
      retransmit_go <= next_retransmit_go;
      retry_exhausted <= next_retry_exhausted;
    end
  end

endmodule // radio_addr_retry_rate_config

`default_nettype wire

// File: verilog/radio_cfg_pkg.sv
/*
  Shared constants and types for the radio configuration register subset:
  register offsets, field positions, reset values, access commands,
  decode enums and the register access carrier.
  Assumes a single 100 MHz clock domain for every user.
*/
`default_nettype none

package radio_cfg_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [4:0] ADDR_ADDRESS_WIDTH_SETUP = 5'h03;
  localparam logic [4:0] ADDR_RETRANSMIT_SETUP = 5'h04;
  localparam logic [4:0] ADDR_RADIO_CHANNEL = 5'h05;
  localparam logic [4:0] ADDR_RADIO_SETUP = 5'h06;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ADDR_LEN_LSB = 0;        // Address length, 2 bits
  localparam int RETRY_LIMIT_LSB = 0;     // Retry limit, 4 bits
  localparam int RETRY_DELAY_LSB = 4;     // Retry delay, 4 bits
  localparam int CHANNEL_LSB = 0;         // Channel, 7 bits
  localparam int TX_POWER_LSB = 1;        // Transmit power, 2 bits
  localparam int RATE_HIGH_BIT = 3;
  localparam int FORCE_LOCK_BIT = 4;
  localparam int RATE_LOW_BIT = 5;
  localparam int CARRIER_TEST_BIT = 7;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] RST_ADDR_LEN = 2'h3;
  localparam logic [3:0] RST_RETRY_DELAY = 4'h0;
  localparam logic [3:0] RST_RETRY_LIMIT = 4'h3;
  localparam logic [6:0] RST_CHANNEL = 7'h02;
  localparam logic RST_CARRIER_TEST = 1'b0;
  localparam logic RST_RATE_LOW = 1'b0;
  localparam logic RST_FORCE_LOCK = 1'b0;
  localparam logic RST_RATE_HIGH = 1'b1;
  localparam logic [1:0] RST_TX_POWER = 2'h3;

  // ----------------------------------------------------------------------
  // Serial access commands (top three bits of the command byte)
  // ----------------------------------------------------------------------
  localparam logic [2:0] CMD_READ_REG = 3'h0;
  localparam logic [2:0] CMD_WRITE_REG = 3'h1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 100;           // mclk rate in MHz
  localparam int RETRY_STEP_US = 250;     // Retry delay step in us
  localparam int RETRY_STEP_CYCLES = RETRY_STEP_US * CLK_MHZ;
  localparam int WAIT_W = 20;             // Holds 16 steps of 25000

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RATE_1M = 2'b00,
    RATE_2M = 2'b01,
    RATE_250K = 2'b10,
    RATE_RESERVED = 2'b11
  } rate_e;

  typedef enum logic [1:0] {
    PWR_M18DBM = 2'b00,
    PWR_M12DBM = 2'b01,
    PWR_M6DBM = 2'b10,
    PWR_0DBM = 2'b11
  } power_e;

  typedef enum logic [0:0] {
    RETRY_IDLE = 1'b0,
    RETRY_WAIT = 1'b1
  } retry_state_e;

  // Register write request from the serial port
  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

`default_nettype wire

// File: verilog/spi_reg_port.sv
/*
  Serial register access port: mode 0 slave, MSB first. First byte is
  the command (read or write plus 5-bit address), following bytes are
  data. Emits a one-cycle write request per data byte and shifts out
  the addressed register on reads.
  Assumes pins are asynchronous to mclk and sck is far slower than mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module spi_reg_port (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spi_csn_b,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  output radio_cfg_pkg::reg_req_s req,
  output logic [4:0] rd_addr,
  input wire logic [7:0] rd_data
);

  // ----------------------------------------------------------------------
  // Pin synchronisers and filtered levels
  // ----------------------------------------------------------------------
  logic [2:0] csn_s, sck_s, mosi_s;   // Three-stage chains
  logic csn_f, sck_f, mosi_f;         // Accepted levels
  logic next_csn_f, next_sck_f, next_mosi_f;

  // A level counts only once stages two and three agree
  always_comb begin
    next_csn_f = (csn_s[1] == csn_s[2]) ? csn_s[2] : csn_f;
    next_sck_f = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_f;
    next_mosi_f = (mosi_s[1] == mosi_s[2]) ? mosi_s[2] : mosi_f;
  end

  // Register the chains and levels
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      csn_s <= 3'h7;
      sck_s <= 3'h0;
      mosi_s <= 3'h0;
      csn_f <= 1'b1;
      sck_f <= 1'b0;
      mosi_f <= 1'b0;
    end else begin
      csn_s <= {csn_s[1:0], spi_csn_b};
      sck_s <= {sck_s[1:0], spi_sck};
      mosi_s <= {mosi_s[1:0], spi_mosi};
      csn_f <= next_csn_f;
      sck_f <= next_sck_f;
      mosi_f <= next_mosi_f;
    end
  end

  // ----------------------------------------------------------------------
  // Byte framing and command decode
  // ----------------------------------------------------------------------
  logic sck_rise, sck_fall;
  logic [2:0] bit_cnt, next_bit_cnt;     // Bit within the byte
  logic in_data, next_in_data;           // Past the command byte
  logic is_write, next_is_write;
  logic load_rd, next_load_rd;           // Reload shifter next cycle
  logic [4:0] addr, next_addr;
  logic [6:0] shift_in, next_shift_in;
  logic [7:0] shift_out, next_shift_out;
  radio_cfg_pkg::reg_req_s next_req;
  logic [7:0] full_byte;

  assign sck_rise = next_sck_f & ~sck_f;
  assign sck_fall = ~next_sck_f & sck_f;
  assign full_byte = {shift_in, mosi_f};

  // Next state of the framing logic
  always_comb begin
    next_bit_cnt = bit_cnt;
    next_in_data = in_data;
    next_is_write = is_write;
    next_load_rd = 1'b0;
    next_addr = addr;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_req = '0;
    next_req.addr = addr;
    next_req.wdata = req.wdata;
    if (load_rd) begin
      // Read data fetched one cycle after the address settles
      next_shift_out = rd_data;
    end
    if (csn_f) begin
      // Deselected: frame restarts at the command byte
      next_bit_cnt = 3'h0;
      next_in_data = 1'b0;
      next_shift_out = 8'h00;
    end else if (sck_rise) begin
      next_shift_in = full_byte[6:0];
      next_bit_cnt = 3'(bit_cnt + 3'h1);
      if (bit_cnt == 3'h7) begin
        if (!in_data) begin
          // Command byte: other codes write nothing; their data bytes reload the shifter as a read does
          next_in_data = 1'b1;
          next_addr = full_byte[4:0];
          next_is_write = (full_byte[7:5] == radio_cfg_pkg::CMD_WRITE_REG);
          next_load_rd = (full_byte[7:5] == radio_cfg_pkg::CMD_READ_REG);
        end else if (is_write) begin
          next_req.wr = 1'b1;
          next_req.wdata = full_byte;
        end else begin
          next_load_rd = 1'b1;
        end
      end
    end else if (sck_fall && bit_cnt != 3'h0) begin
      // Shift after the first bit; the MSB is already on the pin
      next_shift_out = {shift_out[6:0], 1'b0};
    end
  end

  // Register the framing state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt <= 3'h0;
      in_data <= 1'b0;
      is_write <= 1'b0;
      load_rd <= 1'b0;
      addr <= 5'h00;
      shift_in <= 7'h00;
      shift_out <= 8'h00;
      req <= '0;
    end else begin
      bit_cnt <= next_bit_cnt;
      in_data <= next_in_data;
      is_write <= next_is_write;
      load_rd <= next_load_rd;
      addr <= next_addr;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      req <= next_req;
    end
  end

  assign rd_addr = addr;
  assign spi_miso = shift_out[7];
  assign spi_miso_oe = ~csn_f;   // Released while deselected

endmodule // spi_reg_port

`default_nettype wire
